/* rtl/mms_sequencer.sv */
// Slot sequencer of a four-channel supply monitor with bus-valid logic
// Assumes select strobe, enable and comparator levels arrive asynchronously
// Operation
// - Step through enabled slots in fixed order
// - Paired devices alternate drive, start high-Z
// - Every second pass reverses output polarity
// - Outside standby, valid flag low until comparators exceed threshold
// - Only enabled channels affect valid flag
// - Override forces flag low, else release
// - Idle select beyond timeout restarts sequence
// - Enable pin toggle restarts sequence
// - Enable low runs, high is standby
// - Floating enable: comparators only, mux reset
// - Skip nibbles: start pulses, end pulses
// - Mask bits map ground, aux, channels
// - Polarity bit 7 enables swap mode
`timescale 1ns/1ps
`include "mms_regs.svh"
module mms_sequencer (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic slotStepStrobe,
  input wire logic enablePinLow,
  input wire logic enablePinFloat,
  input wire logic overridePin,
  input wire logic [3:0] busSenseInput,
  input wire mms_pkg::mms_cfg_t cfg,
  output mms_pkg::mms_out_t diffOut,
  output logic bandgapOutput,
  output logic busValidFlagOut,
  output logic busValidFlagOe,
  output logic [4:0] slotIndex
);
  localparam int TMO = `MMS_TIMEOUT_CYCLES;
  logic [7:0] syncIn;
  logic stepS, enLowS, enFloatS, ovrS;
  logic [3:0] senseS;
  mms_sync #(.W(8)) uSync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .din({slotStepStrobe, enablePinLow, enablePinFloat, overridePin, busSenseInput}),
    .dout(syncIn)
  );
  assign stepS = syncIn[7];
  assign enLowS = syncIn[6];
  assign enFloatS = syncIn[5];
  assign ovrS = syncIn[4];
  assign senseS = syncIn[3:0];

  function automatic logic slotOn(input logic [7:0] m, input logic [3:0] s);
    logic r;
    r = 1'b0;
    if (s <= 4'h7)
      r = m[s[3:1]];
    else if (s == 4'h8)
      r = m[`MMS_MASK_AUX1_BIT];
    else if (s == 4'h9)
      r = m[`MMS_MASK_AUX2_BIT];
    else if (s == 4'ha)
      r = m[`MMS_MASK_GND_BIT];
    return r;
  endfunction

  // Number of enabled slots in a mask
  function automatic logic [4:0] countOn(input logic [7:0] m);
    logic [4:0] c;
    c = '0;
    for (int i = 0; i < `MMS_SLOT_COUNT; i++)
      c = c + {4'h0, slotOn(m, i[3:0])};
    return c;
  endfunction

  // Slot holding a given rank among the enabled ones
  function automatic logic [3:0] slotAt(input logic [7:0] m, input logic [4:0] rank);
    logic [3:0] r;
    logic [4:0] k;
    r = 4'h0;
    k = '0;
    for (int i = 0; i < `MMS_SLOT_COUNT; i++)
      if (slotOn(m, i[3:0]))
      begin
        if (k == rank)
          r = i[3:0];
        k = k + 5'd1;
      end
    return r;
  endfunction

  mms_pkg::mms_en_level_t enLevel;
  always_comb
  begin
    if (enFloatS)
      enLevel = mms_pkg::MMS_EN_LIMITED;
    else if (enLowS)
      enLevel = mms_pkg::MMS_EN_ON;
    else
      enLevel = mms_pkg::MMS_EN_STANDBY;
  end

  // Sequencer state
  logic stepPrev, enPrev, started, passOdd;
  logic [4:0] pos;
  logic [7:0] mask, skip, pol;
  logic [13:0] idleCnt;
  logic next_stepPrev, next_enPrev, next_started, next_passOdd;
  logic [4:0] next_pos;
  logic [7:0] next_mask, next_skip, next_pol;
  logic [13:0] next_idleCnt;
  mms_pkg::mms_out_t next_diffOut;
  logic [4:0] next_slotIndex;
  logic [4:0] total;
  logic [4:0] enCount;
  logic rise, edgeAny, restart;
  logic [4:0] nextEnCount;
  logic [4:0] ordinal;

  always_comb
  begin
    enCount = countOn(mask);
    total = 5'(skip[7:4]) + enCount + 5'(skip[3:0]);
  end

  always_comb
  begin
    rise = stepS && !stepPrev;
    edgeAny = stepS != stepPrev;
    restart = (enLowS != enPrev)
      || (!cfg.timeoutDisable && (idleCnt >= 14'(TMO)));
    next_stepPrev = stepS;
    next_enPrev = enLowS;
    next_mask = mask;
    next_skip = skip;
    next_pol = pol;
    next_pos = pos;
    next_started = started;
    next_passOdd = passOdd;
    next_idleCnt = (edgeAny || !started) ? '0 : idleCnt + 14'd1;
    if (restart)
    begin
      next_pos = '0;
      next_started = 1'b0;
      next_passOdd = 1'b0;
      next_idleCnt = '0;
    end
    else if (rise)
    begin
      next_started = 1'b1;
      if ((pos == '0) || (pos >= total))
      begin
        // Settings take effect at cycle boundary
        next_mask = cfg.channelEnableMask;
        next_skip = cfg.slotSkipCounts;
        next_pol = cfg.polarityControl;
        next_pos = 5'd1;
        if (pos != '0)
          next_passOdd = !passOdd && pol[`MMS_POL_SWAP_BIT];
      end
      else
        next_pos = pos + 5'd1;
    end
    if (enLevel != mms_pkg::MMS_EN_ON)
    begin
      next_pos = '0;
      next_started = 1'b0;
      next_passOdd = 1'b0;
      next_idleCnt = '0;
      next_mask = cfg.channelEnableMask;
      next_skip = cfg.slotSkipCounts;
      next_pol = cfg.polarityControl;
    end
    next_slotIndex = next_pos;
    // Output decoded from next state so it lines up with slotIndex
    nextEnCount = countOn(next_mask);
    ordinal = next_pos - 5'd1 - 5'(next_skip[7:4]);
    next_diffOut = '0;
    next_diffOut.slot = mms_pkg::mms_slot_t'(slotAt(next_mask, ordinal));
    // Drive only inside enabled window; skipped pulses stay high-Z
    if ((enLevel == mms_pkg::MMS_EN_ON) && (next_pos > 5'(next_skip[7:4]))
      && (next_pos <= 5'(next_skip[7:4]) + nextEnCount))
    begin
      next_diffOut.drive = 1'b1;
      next_diffOut.reversed = next_passOdd;
    end
  end

  // Bus-valid logic
  logic next_bvOut, next_bvOe, next_bg;
  logic allValid;
  always_comb
  begin
    allValid = &(senseS | ~mask[3:0]);
    next_bg = enLevel != mms_pkg::MMS_EN_STANDBY;
    next_bvOut = 1'b0;
    if (ovrS)
      next_bvOe = 1'b1;
    else if (enLevel == mms_pkg::MMS_EN_STANDBY)
      next_bvOe = 1'b0;
    else
      next_bvOe = !allValid;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stepPrev <= 1'b0;
      enPrev <= 1'b0;
      started <= 1'b0;
      passOdd <= 1'b0;
      pos <= '0;
      mask <= `MMS_MASK_RESET;
      skip <= `MMS_SKIP_RESET;
      pol <= 8'h00;
      idleCnt <= '0;
      diffOut <= '0;
      slotIndex <= '0;
      bandgapOutput <= 1'b0;
      busValidFlagOut <= 1'b0;
      busValidFlagOe <= 1'b1;
    end
    else
    begin
      stepPrev <= next_stepPrev;
      enPrev <= next_enPrev;
      started <= next_started;
      passOdd <= next_passOdd;
      pos <= next_pos;
      mask <= next_mask;
      skip <= next_skip;
      pol <= next_pol;
      idleCnt <= next_idleCnt;
      diffOut <= next_diffOut;
      slotIndex <= next_slotIndex;
      bandgapOutput <= next_bg;
      busValidFlagOut <= next_bvOut;
      busValidFlagOe <= next_bvOe;
    end
  end
endmodule

/* rtl/mms_sync.sv */
// Two flip-flop synchroniser for a vector of pin inputs
// Assumes inputs are asynchronous to sys_clk
`timescale 1ns/1ps
module mms_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_dout;
  always_comb
  begin
    next_stage1 = din;
    next_dout = stage1;
  end
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1 <= '0;
      dout <= '0;
    end
    else
    begin
      stage1 <= next_stage1;
      dout <= next_dout;
    end
  end
endmodule

/* shared/mms_pkg.sv */
// Types of the monitor slot sequencer
// Assumes mms_regs.svh is included by the design files
package mms_pkg;
  typedef enum logic [1:0] {
    MMS_EN_ON = 2'b00,
    MMS_EN_STANDBY = 2'b01,
    MMS_EN_LIMITED = 2'b10
  } mms_en_level_t;
  typedef enum logic [3:0] {
    MMS_SL_CH1_BUS = 4'h0, MMS_SL_CH1_SHUNT = 4'h1,
    MMS_SL_CH2_BUS = 4'h2, MMS_SL_CH2_SHUNT = 4'h3,
    MMS_SL_CH3_BUS = 4'h4, MMS_SL_CH3_SHUNT = 4'h5,
    MMS_SL_CH4_BUS = 4'h6, MMS_SL_CH4_SHUNT = 4'h7,
    MMS_SL_AUX1 = 4'h8, MMS_SL_AUX2 = 4'h9, MMS_SL_GND = 4'ha
  } mms_slot_t;
  typedef struct packed {
    logic drive;
    logic reversed;
    mms_slot_t slot;
  } mms_out_t;
  typedef struct packed {
    logic [7:0] channelEnableMask;
    logic [7:0] slotSkipCounts;
    logic [7:0] polarityControl;
    logic timeoutDisable;
  } mms_cfg_t;
endpackage

/* shared/mms_regs.svh */
// Constants of the monitor slot sequencer: field positions, reset values, timing
// Assumes a 250 MHz system clock
`ifndef MMS_REGS_SVH
`define MMS_REGS_SVH
`define MMS_MASK_GND_BIT 7
`define MMS_MASK_AUX2_BIT 5
`define MMS_MASK_AUX1_BIT 4
`define MMS_MASK_RESET 8'h0f
`define MMS_SKIP_RESET 8'h00
`define MMS_POL_SWAP_BIT 7
`define MMS_CLK_PERIOD_PS 4000
`define MMS_TIMEOUT_US 45
`define MMS_TIMEOUT_CYCLES ((`MMS_TIMEOUT_US * 1000000) / `MMS_CLK_PERIOD_PS)
`define MMS_SLOT_COUNT 11
`endif

/* test/mms_ctrl_model.sv */
// Controller model pulsing the select line
// Assumes the bench calls pulse between its checks
`timescale 1ns/1ps
module mms_ctrl_model (
  input wire logic sys_clk,
  output logic slotStepStrobe
);
  initial slotStepStrobe = 1'b0;
  // One 80 ns select period, idle low after it
  task automatic pulse();
    repeat (10) @(negedge sys_clk);
    slotStepStrobe = 1'b1;
    repeat (10) @(negedge sys_clk);
    slotStepStrobe = 1'b0;
  endtask
endmodule

/* test/mms_seq_assertions.sv */
// Port checker of the slot sequencer
// Assumes cfg changes only while the sequencer is off
`timescale 1ns/1ps
module mms_seq_assertions (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic slotStepStrobe,
  input wire logic enablePinLow,
  input wire logic enablePinFloat,
  input wire logic overridePin,
  input wire logic [3:0] busSenseInput,
  input wire mms_pkg::mms_cfg_t cfg,
  input wire mms_pkg::mms_out_t diffOut,
  input wire logic bandgapOutput,
  input wire logic busValidFlagOe,
  input wire logic [4:0] slotIndex
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic up;
  assign up = &(busSenseInput | ~cfg.channelEnableMask[3:0]);
  sequence held_off; (!enablePinLow && !enablePinFloat)[*5]; endsequence
  sequence held_on; (enablePinLow && !enablePinFloat)[*3]; endsequence
  chk_start_hiz: assert property (slotIndex == 5'h00 |-> !diffOut.drive)
    else $error("drive at start position");
  chk_step_moves: assert property (enablePinLow && $rose(slotStepStrobe) ##1 held_on
    |-> $changed(slotIndex))
    else $error("step not taken");
  chk_off_quiet: assert property (held_off |-> !diffOut.drive && !bandgapOutput
    && $stable(slotIndex))
    else $error("active in standby");
  chk_float_reset: assert property (enablePinFloat[*5] |-> !diffOut.drive
    && slotIndex == 5'h00 && bandgapOutput)
    else $error("limited mode wrong");
  chk_override_low: assert property (overridePin[*5] |-> busValidFlagOe)
    else $error("override ignored");
  chk_flag_low: assert property ((!up && (enablePinLow || enablePinFloat))[*5]
    |-> busValidFlagOe)
    else $error("flag released early");
  chk_flag_free: assert property ((up && !overridePin)[*5] |-> !busValidFlagOe)
    else $error("flag held low");
  chk_skip_front: assert property (diffOut.drive
    |-> slotIndex > {1'b0, cfg.slotSkipCounts[7:4]})
    else $error("drive in start skip");
  chk_swap_only: assert property (diffOut.reversed |-> cfg.polarityControl[7])
    else $error("reversed without swap");
endmodule
bind mms_sequencer mms_seq_assertions mms_seq_assertions_i (.sys_clk, .arst_n,
  .slotStepStrobe, .enablePinLow, .enablePinFloat, .overridePin, .busSenseInput,
  .cfg, .diffOut, .bandgapOutput, .busValidFlagOe, .slotIndex);

/* test/mms_sequencer_tb.sv */
// Bench of the slot sequencer
// Assumes the controller model and checker are compiled with it
`timescale 1ns/1ps
module mms_sequencer_tb;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic enablePinLow = 1'b0;
  logic enablePinFloat = 1'b0;
  logic overridePin = 1'b0;
  logic [3:0] busSenseInput = 4'h0;
  mms_pkg::mms_cfg_t cfg = '0;
  logic slotStepStrobe;
  mms_pkg::mms_out_t diffOut;
  logic bandgapOutput;
  logic busValidFlagOut;
  logic busValidFlagOe;
  logic [4:0] slotIndex;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  int p;
  int pos;
  logic [3:0] q[$];
  logic [7:0] cfgs [3][3] = '{'{8'hbf, 8'h0b, 8'h80}, '{8'hbf, 8'hb0, 8'h80},
    '{8'h9a, 8'h00, 8'h00}};
  logic [7:0] flg [7] = '{8'h0f, 8'h0a, 8'h85, 8'h88, 8'h9f, 8'h00, 8'h90};
  always #2 sys_clk = ~sys_clk;
  mms_sequencer mms_sequencer_i (.sys_clk, .arst_n, .slotStepStrobe, .enablePinLow,
    .enablePinFloat, .overridePin, .busSenseInput, .cfg, .diffOut, .bandgapOutput,
    .busValidFlagOut, .busValidFlagOe, .slotIndex);
  mms_ctrl_model mms_ctrl_model_i (.sys_clk, .slotStepStrobe);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wt(input int c);
    repeat (c) @(negedge sys_clk);
  endtask
  function automatic logic en(input logic [7:0] m, input int s);
    return s < 8 ? m[s / 2] : m[s == 8 ? 4 : s == 9 ? 5 : 7];
  endfunction
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      num_errors++;
      conclude();
    end
  end
  initial
  begin
    wt(8);
    arst_n = 1'b1;
    chk(8'(diffOut), 8'h00);
    for (int c = 0; c < 3; c++)
    begin
      enablePinLow = 1'b0;
      mms_ctrl_model_i.pulse();
      chk(8'({bandgapOutput, diffOut.drive, slotIndex}), 8'h00);
      cfg = '{cfgs[c][0], cfgs[c][1], cfgs[c][2], 1'b0};
      wt(8);
      enablePinLow = 1'b1;
      wt(8);
      q = {};
      for (int s = 0; s < 11; s++)
        if (en(cfgs[c][0], s))
          q.push_back(4'(s));
      n = cfgs[c][1][7:4] + q.size() + cfgs[c][1][3:0];
      for (int k = 1; k <= 45; k++)
      begin
        mms_ctrl_model_i.pulse();
        pos = (k - 1) % n + 1;
        p = pos - cfgs[c][1][7:4] - 1;
        chk(8'(slotIndex), 8'(pos));
        if (p >= 0 && p < q.size())
          chk(8'(diffOut), {3'b001, ((k - 1) / n) % 2 == 1 && cfgs[c][2][7], q[p]});
        else
          chk(8'(diffOut.drive), 8'h00);
      end
    end
    enablePinLow = 1'b0;
    wt(8);
    enablePinLow = 1'b1;
    wt(8);
    chk(8'(slotIndex), 8'h00);
    mms_ctrl_model_i.pulse();
    wt(11240);
    chk(8'(slotIndex), 8'h01);
    wt(30);
    chk(8'(slotIndex), 8'h00);
    enablePinLow = 1'b0;
    cfg.timeoutDisable = 1'b1;
    wt(8);
    enablePinLow = 1'b1;
    wt(8);
    mms_ctrl_model_i.pulse();
    wt(11300);
    chk(8'(slotIndex), 8'h01);
    repeat (6) mms_ctrl_model_i.pulse();
    chk(8'(diffOut), 8'h22);
    enablePinFloat = 1'b1;
    wt(8);
    chk(8'({bandgapOutput, diffOut.drive, slotIndex}), 8'h40);
    for (int i = 0; i < 7; i++)
    begin
      {enablePinFloat, enablePinLow} = i < 5 ? 2'b11 : 2'b00;
      {overridePin, busSenseInput} = flg[i][4:0];
      wt(8);
      chk(8'(busValidFlagOe), 8'(flg[i][7]));
    end
    chk(8'(busValidFlagOut), 8'h00);
    conclude();
  end
endmodule
